// [dv/ppda_core_properties.sv]
// Purpose: Port-level checks of the parallel port data-action block.
// Assumes: Wait-free APB slave; act_clk clocks the link outputs.
// Notes:   Bound to every ppda_core instance.
`timescale 1ns/1ps
module ppda_core_properties (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic act_clk,
    input wire logic dq_oe,
    input wire logic sock_wr_valid
);
    // Setup phase of an APB transfer
    sequence s_setup;
        psel && !penable;
    endsequence
    chk_apb_ready: assert property (@(posedge mclk) disable iff (!resetn) s_setup |=> pready)
        else $error("pready missing after setup");
    chk_ready_single: assert property (@(posedge mclk) disable iff (!resetn) pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_cause: assert property (@(posedge mclk) disable iff (!resetn)
        pready |-> $past(psel && !penable)) else $error("pready without setup");
    chk_rdata_idle: assert property (@(posedge mclk) disable iff (!resetn)
        !pready |-> prdata == 32'h0) else $error("prdata outside access");
    chk_err_ready: assert property (@(posedge mclk) disable iff (!resetn) pslverr |-> pready)
        else $error("pslverr without pready");
    chk_unmapped_err: assert property (@(posedge mclk) disable iff (!resetn)
        s_setup ##0 (paddr == 8'hFC) |=> pslverr) else $error("unmapped access accepted");
    chk_misalign_err: assert property (@(posedge mclk) disable iff (!resetn)
        s_setup ##0 (paddr[1:0] != 2'b00) |=> pslverr) else $error("misaligned access accepted");
    // Entry edge may close a sampling state while opening a driving one,
    // so only a drive that already stood one edge must exclude sampling
    chk_drive_excl: assert property (@(posedge act_clk) disable iff (!resetn)
        dq_oe && $past(dq_oe) |-> !sock_wr_valid) else $error("sample and drive together");
endmodule : ppda_core_properties

bind ppda_core ppda_core_properties u_props (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .act_clk(act_clk), .dq_oe(dq_oe), .sock_wr_valid(sock_wr_valid));

// [dv/ppda_core_tb_top.sv]
// Purpose: Register and bus-action tests of the data-action block.
// Assumes: Synchronous protocol, thread 0 after reset.
// Notes:   Reset spans 4 mclk so act_clk sees 3 edges.
`timescale 1ns/1ps
module ppda_core_tb_top;
    logic mclk = 1'b0, act_clk = 1'b0, resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, dq_oe, er;
    logic [7:0] paddr = 8'h00, trig_req = 8'h00, trig_i, addr_i;
    logic [31:0] pwdata = 32'h0, prdata, dq_i, dq_o, sock_rd_data, rd;
    logic [31:0] word_req = 32'h3C3C5A5A, sock_wr_data, pp_ctrl;
    logic sock_rd_pop, sock_wr_valid;
    logic [4:0] sock_sel;
    int n_errors = 0, checked = 0, i;

    ppda_core dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .act_clk(act_clk), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
        .addr_i(addr_i), .trig_i(trig_i), .sock_rd_data(sock_rd_data),
        .sock_rd_pop(sock_rd_pop), .sock_wr_data(sock_wr_data),
        .sock_wr_valid(sock_wr_valid), .sock_sel(sock_sel), .pp_ctrl(pp_ctrl));
    ppda_far_model far (.act_clk(act_clk), .dq_o(dq_o), .dq_oe(dq_oe), .word_req(word_req),
        .trig_req(trig_req), .sock_rd_pop(sock_rd_pop), .dq_i(dq_i), .trig_i(trig_i),
        .addr_i(addr_i), .sock_rd_data(sock_rd_data));

    initial forever #25 mclk = ~mclk;
    initial begin
        #7;
        forever #32 act_clk = ~act_clk;
    end

    // One APB transfer; holds until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hung access
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk

    task automatic end_sim();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    initial begin
        #200000;
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        apb(1'b0, 8'h06, 32'h0);
        chk("misaligned err", {31'h0, er}, 32'h1);
        apb(1'b1, 8'h10, 32'h0001C005);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h08, 32'h1);
        chk("apply refused", {31'h0, er}, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk("status err", {31'h0, rd[1]}, 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl readback", rd, 32'h1);
        apb(1'b1, 8'h10, 32'h0001C084);
        apb(1'b1, 8'h14, 32'h0001C801);
        apb(1'b1, 8'h20, 32'hA5A50001);
        apb(1'b1, 8'h08, 32'h1);
        chk("apply ok", {31'h0, er}, 32'h0);
        for (i = 0; i < 20; i++) begin
            apb(1'b0, 8'h04, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        chk("busy clear", {31'h0, rd[0]}, 32'h0);
        repeat (6) @(negedge act_clk);
        chk("drive enable", {31'h0, dq_oe}, 32'h1);
        chk("drive word", dq_o, 32'hA5A50001);
        repeat (3) @(negedge act_clk);
        chk("drive held", {dq_o[31:1], dq_oe}, 32'hA5A50001);
        @(posedge mclk);
        trig_req <= 8'h01;
        repeat (6) @(negedge act_clk);
        chk("drive released", {31'h0, dq_oe}, 32'h0);
        for (i = 0; i < 20; i++) begin
            apb(1'b0, 8'h30, 32'h0);
            if (rd === word_req) break;
        end
        chk("ingress word", rd, 32'h3C3C5A5A);
        apb(1'b0, 8'h04, 32'h0);
        chk("status run", rd, 32'h00000014);
        chk("socket idle", {25'h0, sock_rd_pop, sock_wr_valid, sock_sel}, 32'h0);
        chk("pp ctrl", pp_ctrl, 32'h0);
        end_sim();
    end
endmodule : ppda_core_tb_top

// [dv/ppda_far_model.sv]
// Purpose: Far-side logic on the shared parallel bus.
// Assumes: Device owns the wire while dq_oe is high.
// Notes:   Changes only after link clock edges.
`timescale 1ns/1ps
module ppda_far_model (
    input wire logic act_clk,
    input wire logic [31:0] dq_o,
    input wire logic dq_oe,
    input wire logic [31:0] word_req,
    input wire logic [7:0] trig_req,
    input wire logic sock_rd_pop,
    output logic [31:0] dq_i,
    output logic [7:0] trig_i,
    output logic [7:0] addr_i,
    output logic [31:0] sock_rd_data
);
    logic [31:0] word_q; // Word offered to the device
    logic [31:0] head_q = 32'h0; // Socket head, fresh per pop
    always_ff @(posedge act_clk) begin
        word_q <= word_req;
        trig_i <= trig_req;
    end
    // Next head word after each dequeue
    always_ff @(posedge act_clk) begin
        if (sock_rd_pop) begin
            head_q <= head_q + 32'h1;
        end
    end
    // Wire level: the device wins while it drives
    assign dq_i = dq_oe ? dq_o : word_q;
    assign addr_i = word_q[7:0];
    assign sock_rd_data = head_q;
endmodule : ppda_far_model

// [verilog/ppda_core.sv]
// Purpose: Data and address actions of a programmable parallel port machine,
//          with an APB register file and a link-clock action machine.
// Assumes: act_clk is the interface clock for synchronous protocols and the
//          internal clock for asynchronous ones; the system picks it.
// Notes:   Configuration crosses by a toggle handshake on APPLY; readback
//          crosses by a free-running snapshot handshake.
`timescale 1ns/1ps
`include "ppda_map.svh"

module ppda_core
    import ppda_pkg::*;
#(
    parameter int DW = 32,
    parameter int AW = 8,
    parameter int SW = 5
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic act_clk,
    input wire logic [DW-1:0] dq_i,
    output logic [DW-1:0] dq_o,
    output logic dq_oe,
    input wire logic [AW-1:0] addr_i,
    input wire logic [`PPDA_TRIG_N-1:0] trig_i,
    input wire logic [DW-1:0] sock_rd_data,
    output logic sock_rd_pop,
    output logic [DW-1:0] sock_wr_data,
    output logic sock_wr_valid,
    output logic [SW-1:0] sock_sel,
    output logic [DW-1:0] pp_ctrl
);

    localparam int PW = `PPDA_TRIG_N + AW + DW;  // Width of sampled pin bundle
    localparam bit HAS_SEL = (AW > 2);          // Thread/socket choice exists
    localparam bit HAS_PPO = (AW >= 8);         // Pp-only option exists

    // -----------------------------------------------------------------------
    // Main clock domain state
    // -----------------------------------------------------------------------
    ppda_ctrl_s ctrl_q;                 // Control word as written
    ppda_state_s st_cfg_q [4];          // State table as written
    logic [DW-1:0] egr_q [4];           // Per-thread egress words
    logic apl_req_q;                    // Apply toggle
    logic apl_ack_s1, apl_ack_s2;       // Apply acknowledge sync
    logic cfg_err_q;                    // Last apply refused for bad config
    logic snp_req_q;                    // Snapshot toggle
    logic snp_ack_s1, snp_ack_s2;       // Snapshot acknowledge sync
    logic [DW-1:0] ing_m_q [4];         // Ingress words, readable copy
    logic [DW-1:0] pp_m_q [4];          // Pp registers, readable copy
    logic [1:0] cur_m_q;                // Current state, readable copy
    logic run_m_q;                      // Machine running, readable copy
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // -----------------------------------------------------------------------
    // Link domain state
    // -----------------------------------------------------------------------
    logic lrst_s1, lrst_n_q;            // Reset brought into link domain
    ppda_ctrl_s lctrl_q;                // Applied control word
    ppda_state_s lst_q [4];             // Applied state table
    logic [DW-1:0] legr_q [4];          // Applied egress words
    logic apl_req_s1, apl_req_s2, apl_seen_q;
    logic snp_req_s1, snp_req_s2, snp_seen_q;
    logic [DW-1:0] snp_ing_q [4];       // Stable snapshot for main domain
    logic [DW-1:0] snp_pp_q [4];
    logic [1:0] snp_cur_q;
    logic snp_run_q;
    logic [DW-1:0] ing_q [4];           // Live ingress words per thread
    logic [DW-1:0] pp_q [4];            // Live processor-port registers
    ppda_lk_e lk_q;                     // Idle or running
    logic [1:0] cur_q;                  // Current programmable state
    logic first_q;                      // First cycle of a state visit
    logic [1:0] thr_q;                  // Active thread
    logic [SW-1:0] sock_q;              // Active socket
    logic ppo_q;                        // Pp-only access latched by address
    logic [PW-1:0] pin_s1, pin_s2;      // Async pin synchroniser
    logic [DW-1:0] dq_o_q;
    logic dq_oe_q, pop_q, swv_q;
    logic [DW-1:0] swd_q, ppc_q;

    // -----------------------------------------------------------------------
    // Configuration checks before apply
    // -----------------------------------------------------------------------
    logic cfg_bad;
    // Any state breaking an action exclusion blocks the whole apply
    always_comb begin
        cfg_bad = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (st_cfg_q[i].in_data && st_cfg_q[i].drive_bus_word) cfg_bad = 1'b1;
            if (ctrl_q.muxed && st_cfg_q[i].in_data && st_cfg_q[i].in_addr) cfg_bad = 1'b1;
            if (ctrl_q.muxed && st_cfg_q[i].drive_bus_word && st_cfg_q[i].drive_address_bus) cfg_bad = 1'b1;
        end
    end

    // -----------------------------------------------------------------------
    // APB slave
    // -----------------------------------------------------------------------
    logic busy, setup, wr_ok, in_tbl;
    logic [1:0] idx;
    assign busy = (apl_req_q != apl_ack_s2);
    assign setup = psel && !penable;
    assign wr_ok = psel && penable && pwrite && pready_q && !pslverr_q;
    assign idx = paddr[3:2];
    assign in_tbl = (paddr[1:0] == 2'h0);

    // Decode at setup; answer valid for the single access cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            if (setup) begin
                if (!in_tbl) begin
                    pslverr_q <= 1'b1;
                end else if (paddr == `PPDA_OFF_CTRL) begin
                    prdata_q <= 32'(ctrl_q);
                    pslverr_q <= pwrite && busy;   // Frozen while crossing
                end else if (paddr == `PPDA_OFF_STATUS) begin
                    prdata_q[`PPDA_STS_BUSY] <= busy;
                    prdata_q[`PPDA_STS_ERR] <= cfg_err_q;
                    prdata_q[`PPDA_STS_RUN] <= run_m_q;
                    prdata_q[`PPDA_STS_STATE_LSB +: 2] <= cur_m_q;
                end else if (paddr == `PPDA_OFF_APPLY) begin
                    pslverr_q <= pwrite && (busy || cfg_bad);
                end else if ({paddr[7:4], 4'h0} == `PPDA_BASE_STATE) begin
                    prdata_q <= 32'(st_cfg_q[idx]);
                    pslverr_q <= pwrite && busy;
                end else if ({paddr[7:4], 4'h0} == `PPDA_BASE_EGRESS) begin
                    prdata_q <= 32'(egr_q[idx]);
                    pslverr_q <= pwrite && busy;
                end else if ({paddr[7:4], 4'h0} == `PPDA_BASE_INGRESS) begin
                    prdata_q <= 32'(ing_m_q[idx]);
                end else if ({paddr[7:4], 4'h0} == `PPDA_BASE_PPREG) begin
                    prdata_q <= 32'(pp_m_q[idx]);
                end else begin
                    pslverr_q <= 1'b1;              // Unmapped address
                end
            end
        end
    end

    // Register writes take effect at the access edge only
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_q <= `PPDA_CTRL_RST;
            for (int i = 0; i < 4; i++) begin
                st_cfg_q[i] <= `PPDA_STATE_RST;
                egr_q[i] <= '0;
            end
        end else if (wr_ok) begin
            if (paddr == `PPDA_OFF_CTRL) begin
                ctrl_q <= pwdata[5:0];
            end else if ({paddr[7:4], 4'h0} == `PPDA_BASE_STATE) begin
                st_cfg_q[idx] <= pwdata[16:0];
            end else if ({paddr[7:4], 4'h0} == `PPDA_BASE_EGRESS) begin
                egr_q[idx] <= pwdata[DW-1:0];
            end
        end
    end

    // Apply toggle and error flag; an apply refused for a bad configuration sets the flag
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            apl_req_q <= 1'b0;
            cfg_err_q <= 1'b0;
        end else if (psel && penable && pwrite && pready_q && paddr == `PPDA_OFF_APPLY) begin
            if (!pslverr_q) begin
                apl_req_q <= !apl_req_q;
                cfg_err_q <= 1'b0;
            end else if (cfg_bad) begin
                cfg_err_q <= 1'b1;
            end
        end
    end

    // Acknowledge synchronisers from the link domain
    always_ff @(posedge mclk) begin
        apl_ack_s1 <= apl_seen_q;
        apl_ack_s2 <= apl_ack_s1;
        snp_ack_s1 <= snp_seen_q;
        snp_ack_s2 <= snp_ack_s1;
    end

    // Snapshot copy: link holds its snapshot still until the next toggle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            snp_req_q <= 1'b0;
            cur_m_q <= 2'h0;
            run_m_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                ing_m_q[i] <= '0;
                pp_m_q[i] <= '0;
            end
        end else if (snp_req_q == snp_ack_s2) begin
            ing_m_q <= snp_ing_q;
            pp_m_q <= snp_pp_q;
            cur_m_q <= snp_cur_q;
            run_m_q <= snp_run_q;
            snp_req_q <= !snp_req_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // -----------------------------------------------------------------------
    // Link domain: reset, handshakes, pin sampling
    // -----------------------------------------------------------------------
    // Reset crosses as a level through two act_clk flops; link clock must run meanwhile
    always_ff @(posedge act_clk) begin
        lrst_s1 <= resetn;
        lrst_n_q <= lrst_s1;
        apl_req_s1 <= apl_req_q;
        apl_req_s2 <= apl_req_s1;
        snp_req_s1 <= snp_req_q;
        snp_req_s2 <= snp_req_s1;
        pin_s1 <= {trig_i, addr_i, dq_i};
        pin_s2 <= pin_s1;
    end

    // Synchronous protocols sample pins directly, asynchronous ones synced
    logic [PW-1:0] pin_v;
    logic [DW-1:0] dat_v;
    logic [AW-1:0] adr_v;
    logic [`PPDA_TRIG_N-1:0] trg_v;
    assign pin_v = lctrl_q.async_mode ? pin_s2 : {trig_i, addr_i, dq_i};
    assign dat_v = pin_v[DW-1:0];
    assign adr_v = lctrl_q.muxed ? dat_v[AW-1:0] : pin_v[DW +: AW];
    assign trg_v = pin_v[DW+AW +: `PPDA_TRIG_N];

    // Apply and snapshot capture in the link domain
    always_ff @(posedge act_clk) begin
        if (!lrst_n_q) begin
            apl_seen_q <= 1'b0;
            snp_seen_q <= 1'b0;
            lctrl_q <= `PPDA_CTRL_RST;
            snp_cur_q <= 2'h0;
            snp_run_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                lst_q[i] <= `PPDA_STATE_RST;
                legr_q[i] <= '0;
                snp_ing_q[i] <= '0;
                snp_pp_q[i] <= '0;
            end
        end else begin
            if (apl_req_s2 != apl_seen_q) begin
                lctrl_q <= ctrl_q;      // Stable: main side frozen while busy
                lst_q <= st_cfg_q;
                legr_q <= egr_q;
                apl_seen_q <= apl_req_s2;
            end
            if (snp_req_s2 != snp_seen_q) begin
                snp_ing_q <= ing_q;
                snp_pp_q <= pp_q;
                snp_cur_q <= cur_q;
                snp_run_q <= (lk_q == lk_run);
                snp_seen_q <= snp_req_s2;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Action machine: next state and source selection
    // -----------------------------------------------------------------------
    ppda_state_s scfg, ncfg;
    ppda_ep_e cur_ep, nxt_ep;
    logic [1:0] nxt;
    logic take, act, stay_run;
    logic [DW-1:0] src_word;
    always_comb begin
        scfg = lst_q[cur_q];
        nxt = cur_q;
        take = 1'b0;
        if (lk_q == lk_idle) begin
            nxt = 2'h0;                 // Start always enters state 0
            take = lctrl_q.run;
        end else if (trg_v[scfg.cond0]) begin
            nxt = scfg.next0;
            take = 1'b1;
        end else if (trg_v[scfg.cond1]) begin
            nxt = scfg.next1;
            take = 1'b1;
        end
        ncfg = lst_q[nxt];
        stay_run = lctrl_q.run;
        act = (lk_q == lk_run) && (first_q || scfg.rpt);
        cur_ep = ppo_q ? ep_ppreg : scfg.ep;
        nxt_ep = ppo_q ? ep_ppreg : ncfg.ep;
        case (nxt_ep)
            ep_reg: src_word = legr_q[thr_q];
            ep_ppreg: src_word = pp_q[thr_q];
            ep_sock: src_word = sock_rd_data;
            default: src_word = '0;     // Reserved endpoint drives zero
        endcase
    end

    always_ff @(posedge act_clk) begin
        if (!lrst_n_q) begin
            lk_q <= lk_idle;
            cur_q <= 2'h0;
            first_q <= 1'b0;
        end else begin
            lk_q <= stay_run ? lk_run : lk_idle;
            cur_q <= stay_run ? nxt : 2'h0;
            first_q <= stay_run && take;    // New visit on any transition
        end
    end

    always_ff @(posedge act_clk) begin
        if (!lrst_n_q) begin
            dq_o_q <= '0;
            dq_oe_q <= 1'b0;
        end else begin
            dq_oe_q <= stay_run && ncfg.drive_bus_word;
            dq_o_q <= (stay_run && ncfg.drive_bus_word) ? src_word : '0;
        end
    end

    // dequeue stage; only sockets hold a queue to pop
    always_ff @(posedge act_clk) begin
        if (!lrst_n_q) begin
            pop_q <= 1'b0;
        end else begin
            pop_q <= stay_run && ncfg.drive_bus_word && (nxt_ep == ep_sock) && (take || ncfg.rpt);
        end
    end

    // Data sampling into register, pp register or socket
    always_ff @(posedge act_clk) begin
        if (!lrst_n_q) begin
            swv_q <= 1'b0;
            swd_q <= '0;
            for (int i = 0; i < 4; i++) begin
                ing_q[i] <= '0;
                pp_q[i] <= '0;
            end
        end else begin
            swv_q <= 1'b0;
            if (act && scfg.in_data) begin
                case (cur_ep)
                    ep_reg: ing_q[thr_q] <= dat_v;
                    ep_ppreg: pp_q[thr_q] <= dat_v;
                    ep_sock: begin
                        swd_q <= dat_v;
                        swv_q <= 1'b1;
                    end
                    default: swv_q <= 1'b0;   // Reserved: word dropped
                endcase
            end
        end
    end

    // Address sampling picks thread, socket or pp-only access
    always_ff @(posedge act_clk) begin
        if (!lrst_n_q) begin
            thr_q <= 2'h0;
            sock_q <= '0;
            ppo_q <= 1'b0;
        end else if (act && scfg.in_addr) begin
            ppo_q <= 1'b0;
            if (!HAS_SEL) begin
                thr_q <= 2'(adr_v);
            end else if (lctrl_q.addr_sock) begin
                sock_q <= SW'(adr_v);
            end else if (HAS_PPO && lctrl_q.pp_only) begin
                ppo_q <= 1'b1;
                thr_q <= adr_v[1:0];
            end else begin
                thr_q <= adr_v[1:0];
            end
        end
    end

    always_ff @(posedge act_clk) begin
        if (!lrst_n_q) begin
            ppc_q <= '0;
        end else begin
            ppc_q <= lctrl_q.pp_mode ? pp_q[0] : '0;
        end
    end

    assign dq_o = dq_o_q;
    assign dq_oe = dq_oe_q;
    assign sock_rd_pop = pop_q;
    assign sock_wr_data = swd_q;
    assign sock_wr_valid = swv_q;
    assign sock_sel = sock_q;
    assign pp_ctrl = ppc_q;

endmodule : ppda_core

// [verilog/ppda_map.svh]
// Purpose: Register offsets, field positions and reset values of the parallel
//          port data-action block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Offsets are grouped in 16-byte regions of four words each.
`ifndef PPDA_MAP_SVH
`define PPDA_MAP_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define PPDA_OFF_CTRL 8'h00
`define PPDA_OFF_STATUS 8'h04
`define PPDA_OFF_APPLY 8'h08
`define PPDA_BASE_STATE 8'h10
`define PPDA_BASE_EGRESS 8'h20
`define PPDA_BASE_INGRESS 8'h30
`define PPDA_BASE_PPREG 8'h40

// ---------------------------------------------------------------------------
// Status fields and reset values
// ---------------------------------------------------------------------------
`define PPDA_STS_BUSY 0
`define PPDA_STS_ERR 1
`define PPDA_STS_RUN 2
`define PPDA_STS_STATE_LSB 4
`define PPDA_CTRL_RST 6'h00
`define PPDA_STATE_RST 17'h00000
`define PPDA_THREADS 4
`define PPDA_TRIG_N 8

`endif

// [verilog/ppda_pkg.sv]
// Purpose: Types shared by the parallel port data-action block.
// Assumes: Four programmable states and four threads.
// Notes:   Field layouts live in the packed structs below.
package ppda_pkg;

    // -----------------------------------------------------------------------
    // Endpoint kinds for sampling destination and driving source
    // -----------------------------------------------------------------------
    typedef enum logic [1:0] {
        ep_reg,
        ep_ppreg,
        ep_sock,
        ep_rsvd
    } ppda_ep_e;

    // One programmable state: actions, endpoint, conditions, targets
    typedef struct packed {
        logic [2:0] cond1;       // Trigger index, second condition
        logic [2:0] cond0;       // Trigger index, first condition
        logic [1:0] next1;       // Target when second condition true
        logic [1:0] next0;       // Target when first condition true
        ppda_ep_e ep;            // Destination or source
        logic rpt;               // Repeat actions until transition
        logic drive_address_bus;           // Drive address (checked only)
        logic drive_bus_word;           // Drive bus word
        logic in_addr;           // Sample address word
        logic in_data;           // Sample data word
    } ppda_state_s;

    // Global control word
    typedef struct packed {
        logic pp_only;           // Address accesses hit pp regs only
        logic addr_sock;         // Address selects socket, not thread
        logic pp_mode;           // Processor-port mode
        logic muxed;             // Address and data share lines
        logic async_mode;        // Asynchronous protocol
        logic run;               // Machine running
    } ppda_ctrl_s;

    // Link-side run state
    typedef enum logic {
        lk_idle,
        lk_run
    } ppda_lk_e;

endpackage : ppda_pkg
